// File: common/dbmsh_pkg.sv
// Purpose: shared constants for the dual bus master serial host
// Assumes: 125 MHz core clock, 8-bit serial register port
// Notes:   register indices are word numbers on the serial port
package dbmsh_pkg;
    // timing
    localparam int CLK_NS  = 8;
    localparam int BIT_NS  = 7350;
    localparam int BIT_CYC = BIT_NS / CLK_NS;
    // structure
    localparam int NCH        = 2;
    localparam int FIFO_DEPTH = 4;
    localparam int TXW        = 16;
    localparam int RXW        = 8;
    localparam int CRCW       = 4;
    localparam int AW         = 5;
    localparam int NREG       = 22;
    localparam logic [CRCW-1:0] CRC_POLY = 4'h3;
    localparam logic [CRCW-1:0] CRC_INIT = 4'h0;
    // register indices
    localparam int         CH_STRIDE  = 5;
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_TXH    = 5'h01;
    localparam logic [4:0] OFS_TXL    = 5'h02;
    localparam logic [4:0] OFS_RXD    = 5'h03;
    localparam logic [4:0] OFS_STAT   = 5'h04;
    localparam logic [4:0] SPARE_BASE = 5'h0a;
    localparam logic [4:0] REG_LAST   = 5'h15;
    // command byte and control fields
    localparam int        CMD_WR_BIT  = 7;
    localparam int        CTRL_IEN_TX = 0;
    localparam int        CTRL_IEN_RX = 1;
    localparam int        CTRL_RUN    = 2;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] SPARE_RST  = 8'h00;
    typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} dbmsh_eng_st_t;
endpackage

// File: common/dbmsh_chan_if.sv
// Purpose: channel link between register side and protocol engine
// Assumes: dbmsh_pkg compiled first
// Notes:   push and pop are single-cycle strobes
`timescale 1ns/10ps
interface dbmsh_chan_if;
    logic                       push;
    logic [dbmsh_pkg::TXW-1:0]  push_data;
    logic                       pop;
    logic [dbmsh_pkg::RXW-1:0]  rx_data;
    logic                       tx_empty;
    logic                       tx_full;
    logic                       rx_ne;
    logic                       rx_full;
    logic                       busy;
    logic                       frame_done;
    logic                       crc_bad;
    modport eng (input push, push_data, pop, output rx_data, tx_empty,
                 tx_full, rx_ne, rx_full, busy, frame_done, crc_bad);
    modport ctl (output push, push_data, pop, input rx_data, tx_empty,
                 tx_full, rx_ne, rx_full, busy, frame_done, crc_bad);
endinterface

// File: src/dbmsh_engine.sv
// Purpose: one bus channel: fifos, crc, bit timing, response capture
// Assumes: resp already synchronised to core_clk
// Notes:   frame is 16 data bits + crc out, 8 data bits + crc back
`timescale 1ns/10ps
module dbmsh_engine #(
    parameter int BIT_CYC = dbmsh_pkg::BIT_CYC,
    parameter int DEPTH   = dbmsh_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   arst_n,
    // control
    input  wire logic   run,
    input  wire logic   resp,
    dbmsh_chan_if.eng   cif,
    // physical layer
    output logic        idle_sel,
    output logic        level
);
    localparam int TXW = dbmsh_pkg::TXW;
    localparam int RXW = dbmsh_pkg::RXW;
    localparam int CW  = dbmsh_pkg::CRCW;
    localparam int PW  = $clog2(BIT_CYC);
    localparam int FA  = $clog2(DEPTH);
    localparam logic [PW-1:0] ZERO_LO = PW'(2 * BIT_CYC / 3);
    localparam logic [PW-1:0] ONE_LO  = PW'(BIT_CYC / 3);
    localparam logic [PW-1:0] SAMPLE  = PW'(5 * BIT_CYC / 6);
    localparam logic [PW-1:0] LAST    = PW'(BIT_CYC - 1);
    localparam logic [4:0]    TX_DL   = 5'(TXW - 1);
    localparam logic [4:0]    TX_END  = 5'(TXW + CW - 1);
    localparam logic [4:0]    RX_DL   = 5'(RXW - 1);
    localparam logic [4:0]    RX_END  = 5'(RXW + CW - 1);

    if (BIT_CYC < 6 || BIT_CYC > 4096 || DEPTH < 2 ||
        (DEPTH & (DEPTH - 1)) != 0) begin
        $error("dbmsh_engine: unsupported BIT_CYC or DEPTH");
    end

    function automatic logic [CW-1:0] crc_step(logic [CW-1:0] c, logic b);
        logic fb;
        fb = c[CW-1] ^ b;
        return {c[CW-2:0], 1'b0} ^ (fb ? dbmsh_pkg::CRC_POLY : '0);
    endfunction

    logic [TXW-1:0] txm [DEPTH];
    logic [RXW-1:0] rxm [DEPTH];
    logic [FA:0]    tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
    dbmsh_pkg::dbmsh_eng_st_t st_r;
    logic [PW-1:0]      phase_r;
    logic [4:0]         bitn_r;
    logic [TXW-1:0]     sh_r;
    logic [CW-1:0]      crc_r;
    logic [RXW+CW-1:0]  rxsh_r;
    logic               cur_bit_r;
    logic               done_r;
    logic               bad_r;
    logic [CW-1:0]      crc_nx;
    logic [TXW-1:0]     sh_nx;
    logic [RXW-1:0]     rx_word;

    // fifo flags
    assign cif.tx_empty = tx_wp_r == tx_rp_r;
    assign cif.tx_full  = (tx_wp_r[FA] != tx_rp_r[FA]) &&
                          (tx_wp_r[FA-1:0] == tx_rp_r[FA-1:0]);
    assign cif.rx_ne    = rx_wp_r != rx_rp_r;
    assign cif.rx_full  = (rx_wp_r[FA] != rx_rp_r[FA]) &&
                          (rx_wp_r[FA-1:0] == rx_rp_r[FA-1:0]);
    assign cif.rx_data  = rxm[rx_rp_r[FA-1:0]];
    assign cif.busy       = st_r != dbmsh_pkg::ST_IDLE;
    assign cif.frame_done = done_r;
    assign cif.crc_bad    = bad_r;

    assign crc_nx  = crc_step(crc_r, cur_bit_r);
    assign sh_nx   = (bitn_r == TX_DL) ? {crc_nx, {(TXW-CW){1'b0}}}
                                       : {sh_r[TXW-2:0], 1'b0};
    assign rx_word = rxsh_r[RXW+CW-1:CW];

    // fifo storage, four entries per direction
    always_ff @(posedge core_clk) begin
        if (cif.push && !cif.tx_full) begin
            txm[tx_wp_r[FA-1:0]] <= cif.push_data;
        end
        if (st_r == dbmsh_pkg::ST_RX && phase_r == LAST &&
            bitn_r == RX_END && rxsh_r[CW-1:0] == crc_r && !cif.rx_full) begin
            rxm[rx_wp_r[FA-1:0]] <= rx_word;
        end
    end

    // frame sequencer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r      <= dbmsh_pkg::ST_IDLE;
            phase_r   <= '0;
            bitn_r    <= '0;
            sh_r      <= '0;
            crc_r     <= dbmsh_pkg::CRC_INIT;
            rxsh_r    <= '0;
            cur_bit_r <= 1'b1;
            done_r    <= 1'b0;
            bad_r     <= 1'b0;
            tx_wp_r   <= '0;
            tx_rp_r   <= '0;
            rx_wp_r   <= '0;
            rx_rp_r   <= '0;
        end else begin
            done_r <= 1'b0;
            bad_r  <= 1'b0;
            if (cif.push && !cif.tx_full) begin
                tx_wp_r <= tx_wp_r + 1'b1;
            end
            if (cif.pop && cif.rx_ne) begin
                rx_rp_r <= rx_rp_r + 1'b1;
            end
            unique case (st_r)
                dbmsh_pkg::ST_IDLE: begin
                    if (run && !cif.tx_empty) begin
                        sh_r      <= txm[tx_rp_r[FA-1:0]];
                        cur_bit_r <= txm[tx_rp_r[FA-1:0]][TXW-1];
                        tx_rp_r   <= tx_rp_r + 1'b1;
                        crc_r     <= dbmsh_pkg::CRC_INIT;
                        phase_r   <= '0;
                        bitn_r    <= '0;
                        st_r      <= dbmsh_pkg::ST_TX;
                    end
                end
                dbmsh_pkg::ST_TX: begin
                    phase_r <= phase_r + 1'b1;
                    if (phase_r == LAST) begin
                        phase_r <= '0;
                        bitn_r  <= bitn_r + 1'b1;
                        if (bitn_r <= TX_DL) begin
                            crc_r <= crc_nx;
                        end
                        sh_r      <= sh_nx;
                        cur_bit_r <= sh_nx[TXW-1];
                        if (bitn_r == TX_END) begin
                            bitn_r    <= '0;
                            crc_r     <= dbmsh_pkg::CRC_INIT;
                            cur_bit_r <= 1'b1;
                            st_r      <= dbmsh_pkg::ST_RX;
                        end
                    end
                end
                dbmsh_pkg::ST_RX: begin
                    phase_r <= phase_r + 1'b1;
                    if (phase_r == SAMPLE) begin
                        rxsh_r <= {rxsh_r[RXW+CW-2:0], resp};
                        if (bitn_r <= RX_DL) begin
                            crc_r <= crc_step(crc_r, resp);
                        end
                    end
                    if (phase_r == LAST) begin
                        phase_r <= '0;
                        bitn_r  <= bitn_r + 1'b1;
                        if (bitn_r == RX_END) begin
                            done_r <= 1'b1;
                            bad_r  <= rxsh_r[CW-1:0] != crc_r;
                            if (rxsh_r[CW-1:0] == crc_r && !cif.rx_full) begin
                                rx_wp_r <= rx_wp_r + 1'b1;
                            end
                            st_r <= dbmsh_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // return-to-one bit shaping toward the driver
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_sel <= 1'b1;
            level    <= 1'b1;
        end else begin
            idle_sel <= st_r == dbmsh_pkg::ST_IDLE;
            if (st_r == dbmsh_pkg::ST_IDLE) begin
                level <= 1'b1;
            end else begin
                level <= phase_r >= (cur_bit_r ? ONE_LO : ZERO_LO);
            end
        end
    end
endmodule

// File: src/dbmsh_top.sv
// Purpose: serial register port, interrupt and two bus channels
// Assumes: serial mode with capture on sclk rise, shift on sclk fall
// Notes:   command byte = write flag in bit 7, register index in 4:0
`timescale 1ns/10ps

module dbmsh_top #(
    parameter int BIT_CYC = dbmsh_pkg::BIT_CYC,
    parameter int DEPTH   = dbmsh_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    // serial register port
    input  wire logic                       spi_cs_n,
    input  wire logic                       spi_sclk,
    input  wire logic                       spi_mosi,
    output logic                            spi_miso,
    output logic                            spi_miso_oe,
    // open-drain interrupt
    output logic                            irq_n,
    output logic                            irq_n_oe,
    // physical layer, one bit per channel
    output logic [dbmsh_pkg::NCH-1:0]       idle_signal_select,
    output logic [dbmsh_pkg::NCH-1:0]       signal_level_select,
    input  wire logic [dbmsh_pkg::NCH-1:0]  slave_response_detect
);
    localparam int NCH = dbmsh_pkg::NCH;

    if (NCH * dbmsh_pkg::CH_STRIDE > int'(dbmsh_pkg::SPARE_BASE)) begin
        $error("dbmsh_top: channel registers overlap spare registers");
    end

    // input synchronisers; stage 0 feeds stage 1 only
    logic [2:0]     cs_s;
    logic [2:0]     sck_s;
    logic [1:0]     mosi_s;
    logic [NCH-1:0] resp_m;
    logic [NCH-1:0] resp_s;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_s   <= 3'h7;
            sck_s  <= 3'h0;
            mosi_s <= 2'h0;
            resp_m <= '0;
            resp_s <= '0;
        end else begin
            cs_s   <= {cs_s[1:0], spi_cs_n};
            sck_s  <= {sck_s[1:0], spi_sclk};
            mosi_s <= {mosi_s[0], spi_mosi};
            resp_m <= slave_response_detect;
            resp_s <= resp_m;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;

    assign cs_fall  = !cs_s[1] && cs_s[2];
    assign cs_rise  = cs_s[1] && !cs_s[2];
    assign sck_rise = sck_s[1] && !sck_s[2] && !cs_s[1] && !cs_s[2];
    assign sck_fall = !sck_s[1] && sck_s[2] && !cs_s[1] && !cs_s[2];

    // serial byte framing
    logic [2:0]                 bit_cnt_r;
    logic [7:0]                 sh_in_r;
    logic [7:0]                 sh_out_r;
    logic [dbmsh_pkg::AW-1:0]   addr_r;
    logic                       wr_r;
    logic                       first_r;
    logic                       seen_r;
    logic                       miso_r;
    logic                       miso_oe_r;
    logic [7:0]                 in_byte;
    logic                       byte_done;
    logic                       byte_end;
    logic                       wr_ev;
    logic                       rd_load;
    logic [dbmsh_pkg::AW-1:0]   rd_addr;
    logic [7:0]                 rdata;

    assign in_byte   = {sh_in_r[6:0], mosi_s[1]};
    assign byte_done = sck_rise && bit_cnt_r == 3'h7;
    // end of a serial byte: chip select rise or first rise of next byte
    assign byte_end  = cs_rise || (sck_rise && bit_cnt_r == 3'h0 && seen_r);
    assign wr_ev     = byte_done && !first_r && wr_r;
    assign rd_load   = byte_done &&
                       (first_r ? !in_byte[dbmsh_pkg::CMD_WR_BIT] : !wr_r);
    assign rd_addr   = first_r ? in_byte[dbmsh_pkg::AW-1:0]
                               : addr_r + 1'b1;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_r <= 3'h0;
            sh_in_r   <= 8'h00;
            addr_r    <= '0;
            wr_r      <= 1'b0;
            first_r   <= 1'b1;
            seen_r    <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt_r <= 3'h0;
            first_r   <= 1'b1;
            seen_r    <= 1'b0;
        end else if (sck_rise) begin
            sh_in_r   <= in_byte;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (byte_done) begin
                seen_r  <= 1'b1;
                first_r <= 1'b0;
                if (first_r) begin
                    addr_r <= in_byte[dbmsh_pkg::AW-1:0];
                    wr_r   <= in_byte[dbmsh_pkg::CMD_WR_BIT];
                end else begin
                    addr_r <= addr_r + 1'b1;
                end
            end
        end
    end

    // read data shifts out msb first, changing on falling edges
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_out_r  <= 8'h00;
            miso_r    <= 1'b0;
            miso_oe_r <= 1'b0;
        end else begin
            miso_oe_r <= !cs_s[1];
            if (cs_fall) begin
                sh_out_r <= 8'h00;
                miso_r   <= 1'b0;
            end else if (byte_done) begin
                sh_out_r <= rd_load ? rdata : 8'h00;
            end else if (sck_fall) begin
                miso_r   <= sh_out_r[7];
                sh_out_r <= {sh_out_r[6:0], 1'b0};
            end
        end
    end

    assign spi_miso    = miso_r;
    assign spi_miso_oe = miso_oe_r;

    // spare registers fill out the map
    logic [7:0] spare_r [dbmsh_pkg::SPARE_BASE:dbmsh_pkg::REG_LAST];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = dbmsh_pkg::SPARE_BASE; i <= dbmsh_pkg::REG_LAST; i++)
            begin
                spare_r[i] <= dbmsh_pkg::SPARE_RST;
            end
        end else if (wr_ev && addr_r >= dbmsh_pkg::SPARE_BASE &&
                     addr_r <= dbmsh_pkg::REG_LAST) begin
            spare_r[addr_r] <= in_byte;
        end
    end

    // per-channel views for the read mux
    logic [7:0]     ctrl_w [NCH];
    logic [7:0]     txh_w  [NCH];
    logic [7:0]     rxd_w  [NCH];
    logic [7:0]     stat_w [NCH];
    logic [NCH-1:0] irq_req;

    always_comb begin
        rdata = 8'h00;
        for (int c = 0; c < NCH; c++) begin
            if (rd_addr == 5'(c * dbmsh_pkg::CH_STRIDE) + dbmsh_pkg::OFS_CTRL)
                rdata = ctrl_w[c];
            if (rd_addr == 5'(c * dbmsh_pkg::CH_STRIDE) + dbmsh_pkg::OFS_TXH)
                rdata = txh_w[c];
            if (rd_addr == 5'(c * dbmsh_pkg::CH_STRIDE) + dbmsh_pkg::OFS_RXD)
                rdata = rxd_w[c];
            if (rd_addr == 5'(c * dbmsh_pkg::CH_STRIDE) + dbmsh_pkg::OFS_STAT)
                rdata = stat_w[c];
        end
        if (rd_addr >= dbmsh_pkg::SPARE_BASE &&
            rd_addr <= dbmsh_pkg::REG_LAST) begin
            rdata = spare_r[rd_addr];
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        localparam logic [4:0] BASE = 5'(g * dbmsh_pkg::CH_STRIDE);

        dbmsh_chan_if cif ();

        logic [7:0] channel_control_reg;
        logic [7:0] txh_r;
        logic       it_tx_r;
        logic       it_rx_r;
        logic       crc_err_r;

        // write to the low transmit byte queues a whole frame word
        assign cif.push      = wr_ev && addr_r == BASE + dbmsh_pkg::OFS_TXL;
        assign cif.push_data = {txh_r, in_byte};
        assign cif.pop       = rd_load && rd_addr == BASE + dbmsh_pkg::OFS_RXD;

        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                channel_control_reg <= dbmsh_pkg::CTRL_RST;
                txh_r               <= 8'h00;
            end else if (wr_ev) begin
                if (addr_r == BASE + dbmsh_pkg::OFS_CTRL)
                    channel_control_reg <= in_byte;
                if (addr_r == BASE + dbmsh_pkg::OFS_TXH)
                    txh_r <= in_byte;
            end
        end

        // sticky events: a set in the same cycle as a clear wins
        always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
                it_tx_r   <= 1'b0;
                it_rx_r   <= 1'b0;
                crc_err_r <= 1'b0;
            end else begin
                if (cif.frame_done && cif.tx_empty)
                    it_tx_r <= 1'b1;
                else if (byte_end && !cif.tx_empty)
                    it_tx_r <= 1'b0;
                if (cif.frame_done && cif.rx_ne)
                    it_rx_r <= 1'b1;
                else if (byte_end && !cif.rx_ne)
                    it_rx_r <= 1'b0;
                if (cif.crc_bad)
                    crc_err_r <= 1'b1;
                else if (rd_load && rd_addr == BASE + dbmsh_pkg::OFS_STAT)
                    crc_err_r <= 1'b0;
            end
        end

        assign irq_req[g] =
            (it_tx_r && channel_control_reg[dbmsh_pkg::CTRL_IEN_TX]) ||
            (it_rx_r && channel_control_reg[dbmsh_pkg::CTRL_IEN_RX]);

        assign ctrl_w[g] = channel_control_reg;
        assign txh_w[g]  = txh_r;
        assign rxd_w[g]  = cif.rx_data;
        assign stat_w[g] = {it_rx_r, it_tx_r, cif.busy, crc_err_r,
                            cif.rx_full, cif.rx_ne, cif.tx_full, cif.tx_empty};

        dbmsh_engine #(
            .BIT_CYC (BIT_CYC),
            .DEPTH   (DEPTH)
        ) u_eng (
            .core_clk (core_clk),
            .arst_n   (arst_n),
            .run      (channel_control_reg[dbmsh_pkg::CTRL_RUN]),
            .resp     (resp_s[g]),
            .cif      (cif.eng),
            .idle_sel (idle_signal_select[g]),
            .level    (signal_level_select[g])
        );
    end

    // open-drain pin: only ever pulls low
    logic irq_n_r;
    logic irq_oe_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_n_r  <= 1'b0;
            irq_oe_r <= 1'b0;
        end else begin
            irq_n_r  <= 1'b0;
            irq_oe_r <= |irq_req;
        end
    end

    assign irq_n    = irq_n_r;
    assign irq_n_oe = irq_oe_r;
endmodule

// File: verif/dbmsh_props_properties.sv
// Purpose: port checks on the serial port, interrupt and bus levels
// Assumes: one bound instance per dbmsh_top
// Notes:   bit low time is counted on channel 0 only
`timescale 1ns/10ps
module dbmsh_props #(
    parameter int BIT_CYC = 12
) (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       arst_n,
    // watched pins
    input wire logic       spi_cs_n,
    input wire logic       spi_sclk,
    input wire logic       spi_miso,
    input wire logic       spi_miso_oe,
    input wire logic       irq_n,
    input wire logic [1:0] idle_signal_select,
    input wire logic [1:0] signal_level_select
);
    logic [11:0] lo_cnt_r;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            lo_cnt_r <= 12'h000;
        else if (signal_level_select[0])
            lo_cnt_r <= 12'h000;
        else
            lo_cnt_r <= lo_cnt_r + 12'h001;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence cs_sel_s;
        $fell(spi_cs_n) ##1 !spi_cs_n;
    endsequence
    oe_on_a: assert property (cs_sel_s |-> ##[1:4] spi_miso_oe)
        else $error("miso not driven after select");
    oe_hold_a: assert property ((!spi_cs_n)[*5] |-> spi_miso_oe)
        else $error("miso released while selected");
    oe_off_a: assert property (spi_cs_n[*5] |-> !spi_miso_oe)
        else $error("miso driven while deselected");
    miso_fall_a: assert property ($changed(spi_miso) |-> !spi_sclk)
        else $error("miso changed while sclk high");
    miso_quiet_a: assert property (spi_cs_n[*6] |-> $stable(spi_miso))
        else $error("miso moved while deselected");
    irq_od_a: assert property (!irq_n)
        else $error("interrupt pin driven high");
    idle_lvl_a: assert property ((idle_signal_select
        & ~signal_level_select) == 2'h0) else $error("idle with level low");
    bit_low_a: assert property ($rose(signal_level_select[0]) |->
        lo_cnt_r == BIT_CYC/3 || lo_cnt_r == 2*BIT_CYC/3)
        else $error("bit low time wrong");
endmodule
bind dbmsh_top dbmsh_props #(.BIT_CYC(BIT_CYC)) u_props (
    .core_clk(core_clk), .arst_n(arst_n), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .irq_n(irq_n), .idle_signal_select(idle_signal_select),
    .signal_level_select(signal_level_select));

// File: verif/dbmsh_mcu_model.sv
// Purpose: serial port master standing in for the host controller
// Assumes: mode 0, msb first, sclk half period of 5 core clocks
// Notes:   first returned byte of a transaction is discarded
`timescale 1ns/10ps
module dbmsh_mcu (
    // clock
    input wire logic core_clk,
    // serial master pins
    output logic     spi_cs_n,
    output logic     spi_sclk,
    output logic     spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    task automatic half();
        repeat (5) @(negedge core_clk);
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            half();
            rx[i] = spi_miso;
            spi_sclk = 1'b1;
            half();
            spi_sclk = 1'b0;
        end
    endtask
    task automatic xact(input logic [7:0] c, input logic [31:0] w,
                        input int n, output logic [31:0] r);
        logic [7:0] b;
        r = 32'h0;
        spi_cs_n = 1'b0;
        half();
        xfer(c, b);
        for (int k = 0; k < n; k++) begin
            xfer(w[8*(n-1-k) +: 8], b);
            r = {r[23:0], b};
        end
        half();
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        half();
        half();
    endtask
endmodule

// File: verif/tb.sv
// Purpose: self-checking bench for dbmsh_top
// Assumes: short bit period of 12 core clocks
// Notes:   channel 0 carries the bus traffic
`timescale 1ns/10ps
module tb;
    logic        core_clk;
    logic        arst_n;
    logic [1:0]  resp;
    logic        cs_n, sclk, mosi, miso, miso_oe, miso_w, irq_n, irq_oe;
    logic [1:0]  idle, lvl;
    logic [31:0] rd;
    int          mismatches;
    int          cmp_count;
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    assign miso_w = miso_oe ? miso : ~miso;
    dbmsh_top #(.BIT_CYC(12), .DEPTH(4)) dut (.core_clk(core_clk),
        .arst_n(arst_n), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe(miso_oe), .irq_n(irq_n),
        .irq_n_oe(irq_oe), .idle_signal_select(idle),
        .signal_level_select(lvl), .slave_response_detect(resp));
    dbmsh_mcu mcu (.core_clk(core_clk), .spi_cs_n(cs_n), .spi_sclk(sclk),
        .spi_mosi(mosi), .spi_miso(miso_w));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic frame();
        for (int v = 0; v < 2; v++) begin
            for (int n = 0; n < 2000 && idle[0] !== v[0]; n++)
                @(negedge core_clk);
            chk(idle[0], v);
        end
        repeat (4) @(negedge core_clk);
    endtask
    task automatic t_regs();
        mcu.xact(8'h8a, 32'ha55a3c, 3, rd);
        mcu.xact(8'h0a, 32'h0, 3, rd);
        chk(rd, 32'ha55a3c);
        mcu.xact(8'h95, 32'h77ff, 2, rd);
        mcu.xact(8'h15, 32'h0, 2, rd);
        chk(rd, 32'h7700);
    endtask
    task automatic t_frame();
        mcu.xact(8'h80, 32'h07, 1, rd);
        mcu.xact(8'h81, 32'h1000, 2, rd);
        frame();
        chk(irq_oe, 1);
        mcu.xact(8'h03, 32'h0, 1, rd);
        chk(rd, 32'h0);
        mcu.xact(8'h04, 32'h0, 1, rd);
        chk(rd, 32'h41);
        mcu.xact(8'h80, 32'h04, 1, rd);
        repeat (4) @(negedge core_clk);
        chk(irq_oe, 0);
    endtask
    task automatic t_crc();
        resp = 2'h1;
        mcu.xact(8'h81, 32'h2000, 2, rd);
        frame();
        chk(irq_oe, 0);
        mcu.xact(8'h04, 32'h0, 1, rd);
        chk(rd, 32'h51);
        mcu.xact(8'h04, 32'h0, 1, rd);
        chk(rd, 32'h41);
    endtask
    task automatic t_fifo();
        mcu.xact(8'h80, 32'h00, 1, rd);
        repeat (3) mcu.xact(8'h81, 32'h3000, 2, rd);
        mcu.xact(8'h00, 32'h0, 2, rd);
        chk(rd, 32'h0030);
        mcu.xact(8'h04, 32'h0, 1, rd);
        chk(rd, 32'h00);
        mcu.xact(8'h81, 32'h3000, 2, rd);
        mcu.xact(8'h04, 32'h0, 1, rd);
        chk(rd, 32'h02);
    endtask
    initial begin
        arst_n = 1'b0;
        resp = 2'h0;
        mismatches = 0;
        cmp_count = 0;
        repeat (19) @(negedge core_clk);
        chk({idle, lvl, miso_oe, irq_oe}, 32'h3c);
        @(negedge core_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        t_regs();
        t_frame();
        t_crc();
        t_fifo();
        end_sim();
    end
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule
